// ---- hw/dhb_host_frontend.sv ----
// Host bus front end: parallel and serial byte capture for the display driver
//
// Operation
// - Reset pin low keeps front end initialised
// - Strobes ignored unless chip select low
// - Select high means data, low command
// - Two-wire mode: select pin is address bit
// - Strap code picks one of five modes
// - 6800 direction low writes, high reads
// - 6800 latches on enable falling edge
// - Reads return status or RAM data
// - 8080 read completes on strobe rising edge
// - 8080 write latches on strobe rising edge
// - 4-wire shifts eight bits, MSB first
// - 4-wire samples select, writes on eighth
// - Serial modes write only
// - 3-wire frames are nine bits, flag first
// - 3-wire flag one means data
// - Serial clock bit0, data bit1
// - Display off: rows float, columns grounded
`default_nettype none
`include "dhb_defs.svh"

module dhb_host_frontend (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic hwResetInN,
   input wire logic chipSelN,
   input wire logic dataCmdSel,
   input wire logic strobeERdN,
   input wire logic rwWrN,
   input wire logic [2:0] busModeSel,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   input wire logic [7:0] statusIn,
   input wire logic [7:0] frameRdData,
   output logic frameRdNext,
   output logic wrValid,
   input wire logic wrReady,
   output logic [7:0] wrData,
   output logic wrIsData,
   output logic wrOverrun,
   output logic targetAddrLsb,
   output dhb_pkg::dhb_mode_t busMode,
   input wire logic displayOn,
   output logic rowDriversOe,
   output logic columnDriversEn,
   output logic frontendInit
);
   import dhb_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic [`DHB_PIN_W-1:0] pinRaw;
   logic [`DHB_PIN_W-1:0] pinMeta;
   logic [`DHB_PIN_W-1:0] pinSync;
   logic [`DHB_PIN_W-1:0] pinPrev;

   assign pinRaw = {hwResetInN, chipSelN, dataCmdSel, strobeERdN, rwWrN, busModeSel, dataIn};

   // Meta stage feeds only the second stage
   // No reset here: a cleared stage would fake strobe edges
   // and hand a zero strap to the mode capture after srst
   always_ff @(posedge sys_clk) begin
      pinMeta <= pinRaw;
   end

   always_ff @(posedge sys_clk) begin
      pinSync <= pinMeta;
   end

   always_ff @(posedge sys_clk) begin
      pinPrev <= pinSync;
   end

   // ==========================================
   // Synchronised pin views and edges
   logic rstPinN;
   logic csN;
   logic dcSel;
   logic eRd;
   logic eRdPrev;
   logic rwWr;
   logic rwWrPrev;
   logic sclk;
   logic sclkPrev;
   logic serial_in_line;
   logic [2:0] strapSync;
   logic [7:0] busByte;

   assign rstPinN = pinSync[`DHB_PIN_RSTN];
   assign csN = pinSync[`DHB_PIN_CSN];
   assign dcSel = pinSync[`DHB_PIN_DC];
   assign eRd = pinSync[`DHB_PIN_ERD];
   assign eRdPrev = pinPrev[`DHB_PIN_ERD];
   assign rwWr = pinSync[`DHB_PIN_RWWR];
   assign rwWrPrev = pinPrev[`DHB_PIN_RWWR];
   assign strapSync = pinSync[`DHB_PIN_BS_HI:`DHB_PIN_BS_LO];
   assign busByte = pinSync[`DHB_PIN_D_HI:`DHB_PIN_D_LO];
   assign sclk = pinSync[`DHB_PIN_SCLK];
   assign sclkPrev = pinPrev[`DHB_PIN_SCLK];
   assign serial_in_line = pinSync[`DHB_PIN_SERIAL_IN_LINE];

   // ==========================================
   // Internal reset
   // pin reset joins srst
   logic initActive;
   assign initActive = srst || !rstPinN;

   // ==========================================
   // Mode strap decode
   dhb_mode_t strapMode;
   dhb_mode_t next_busMode;

   assign strapMode = (strapSync == `DHB_BS_TWO_WIRE) ? DHB_TWO_WIRE :
                      (strapSync == `DHB_BS_P6800) ? DHB_P6800 :
                      (strapSync == `DHB_BS_P8080) ? DHB_P8080 :
                      (strapSync == `DHB_BS_SPI4) ? DHB_SPI4 :
                      (strapSync == `DHB_BS_SPI3) ? DHB_SPI3 : DHB_NONE;

   // Strap caught while the reset pin is low (srst loads DHB_NONE), so a mid-run change cannot split a transfer
   assign next_busMode = initActive ? strapMode : busMode;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busMode <= DHB_NONE;
      end else begin
         busMode <= next_busMode;
      end
   end

   logic mode6800;
   logic mode8080;
   logic modeSpi4;
   logic modeSpi3;
   logic modeTwoWire;
   logic modeSerial;
   logic modeParallel;

   assign mode6800 = (busMode == DHB_P6800);
   assign mode8080 = (busMode == DHB_P8080);
   assign modeSpi4 = (busMode == DHB_SPI4);
   assign modeSpi3 = (busMode == DHB_SPI3);
   assign modeTwoWire = (busMode == DHB_TWO_WIRE);
   assign modeSerial = modeSpi4 || modeSpi3;
   assign modeParallel = mode6800 || mode8080;

   // ==========================================
   // Parallel strobe decode
   // Pin edges are seen two clocks after they happen
   logic selected;
   logic eFall;
   logic rdRise;
   logic wrRise;
   logic parWrite;
   logic parReadDone;
   logic parReadActive;
   logic wr6800;
   logic wr8080;
   logic rd6800Done;
   logic rd8080Done;
   logic rd6800Active;
   logic rd8080Active;

   assign selected = !csN && !initActive;
   assign eFall = eRdPrev && !eRd;
   assign rdRise = !eRdPrev && eRd;
   assign wrRise = !rwWrPrev && rwWr;

   assign wr6800 = mode6800 && eFall && !rwWr;
   assign rd6800Done = mode6800 && eFall && rwWr;
   assign wr8080 = mode8080 && wrRise;
   // 8080 read needs the write strobe parked high
   assign rd8080Done = mode8080 && rdRise && rwWr;
   // Bus driven only while the read strobe is active
   assign rd6800Active = mode6800 && eRd && rwWr;
   assign rd8080Active = mode8080 && !eRd && rwWr;
   assign parWrite = selected && (wr6800 || wr8080);
   assign parReadDone = selected && (rd6800Done || rd8080Done);
   assign parReadActive = selected && (rd6800Active || rd8080Active);

   // ==========================================
   // Read path
   // dummy read; latch returns previous fetch
   logic [7:0] readLatch;
   logic [7:0] next_readLatch;
   logic [7:0] readSel;
   logic ramReadDone;

   assign ramReadDone = parReadDone && dcSel;
   assign next_readLatch = ramReadDone ? frameRdData : readLatch;
   // status on command reads, RAM data otherwise
   assign readSel = dcSel ? readLatch : statusIn;

   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         readLatch <= `DHB_BYTE_ZERO;
         frameRdNext <= 1'b0;
      end else begin
         readLatch <= next_readLatch;
         frameRdNext <= ramReadDone;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         dataOut <= `DHB_BYTE_ZERO;
         dataOe <= 1'b0;
      end else begin
         dataOut <= readSel;
         dataOe <= parReadActive && modeParallel;
      end
   end

   // ==========================================
   // Serial shifter
   logic [`DHB_SHIFT_W-1:0] shiftReg;
   logic [`DHB_SHIFT_W-1:0] next_shiftReg;
   logic [3:0] bitCount;
   logic [3:0] next_bitCount;
   logic [3:0] frameBits;
   logic sclkRise;
   logic serialBit;
   logic serialDone;
   logic lastBit;
   logic serialIsData;
   logic [7:0] serialByte;

   assign frameBits = modeSpi3 ? `DHB_SPI3_BITS : `DHB_SPI4_BITS;
   // rising serial clock shifts a bit
   assign sclkRise = !sclkPrev && sclk;
   assign serialBit = selected && modeSerial && sclkRise;
   // Count ends at eight or nine bits per mode
   assign lastBit = (bitCount + `DHB_CNT_ONE) == frameBits;
   // frame ends on bit eight or nine
   assign serialDone = serialBit && lastBit;
   // MSB first into the low end
   assign next_shiftReg = serialBit ? {shiftReg[`DHB_SHIFT_W-2:0], serial_in_line} : shiftReg;
   assign serialByte = next_shiftReg[7:0];
   // Select pin left unused in 3-wire framing
   // select sampled on the eighth clock
   assign serialIsData = modeSpi3 ? next_shiftReg[8] : dcSel;

   assign next_bitCount = csN ? `DHB_CNT_ZERO :
                          serialDone ? `DHB_CNT_ZERO :
                          serialBit ? (bitCount + `DHB_CNT_ONE) : bitCount;

   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         shiftReg <= '0;
         bitCount <= `DHB_CNT_ZERO;
      end else begin
         shiftReg <= next_shiftReg;
         bitCount <= next_bitCount;
      end
   end

   // ==========================================
   // Write capture into the buffer
   logic capValid;
   logic capReady;
   logic [`DHB_WORD_W-1:0] capWord;
   logic [`DHB_WORD_W-1:0] bufWord;

   // Serial and parallel words never meet in one mode
   // select high is data, low is command
   // byte written in the same clock
   assign capValid = parWrite || serialDone;
   assign capWord = serialDone ? {serialIsData, serialByte} : {dcSel, busByte};

   // Host cannot be stalled; a word arriving into a full buffer sets the sticky wrOverrun flag
   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         wrOverrun <= 1'b0;
      end else if (capValid && !capReady) begin
         wrOverrun <= 1'b1;
      end
   end

   dhb_skid_buffer #(
      .WIDTH(`DHB_WORD_W)
   ) u_buffer (
      .sys_clk(sys_clk),
      .srst(initActive),
      .inValid(capValid),
      .inReady(capReady),
      .inData(capWord),
      .outValid(wrValid),
      .outReady(wrReady),
      .outData(bufWord)
   );

   assign wrIsData = bufWord[8];
   assign wrData = bufWord[7:0];

   // ==========================================
   // Two-wire address bit
   // select pin becomes the address bit
   logic next_targetAddrLsb;
   assign next_targetAddrLsb = modeTwoWire ? dcSel : 1'b0;

   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         targetAddrLsb <= 1'b0;
      end else begin
         targetAddrLsb <= next_targetAddrLsb;
      end
   end

   // ==========================================
   // Panel driver enables and init flag
   // display off floats rows, grounds columns
   always_ff @(posedge sys_clk) begin
      if (initActive) begin
         rowDriversOe <= 1'b0;
         columnDriversEn <= 1'b0;
         frontendInit <= 1'b1;
      end else begin
         rowDriversOe <= displayOn;
         columnDriversEn <= displayOn;
         frontendInit <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ---- hw/dhb_defs.svh ----
// Constants for the display host bus front end
`ifndef DHB_DEFS_SVH
`define DHB_DEFS_SVH

// ==========================================
// Bus mode strap codes
`define DHB_BS_TWO_WIRE 3'h2
`define DHB_BS_P6800 3'h4
`define DHB_BS_P8080 3'h6
`define DHB_BS_SPI4 3'h0
`define DHB_BS_SPI3 3'h1
`define DHB_BS_NONE 3'h7

// ==========================================
// Synchroniser bundle layout
`define DHB_PIN_W 16
`define DHB_PIN_RSTN 15
`define DHB_PIN_CSN 14
`define DHB_PIN_DC 13
`define DHB_PIN_ERD 12
`define DHB_PIN_RWWR 11
`define DHB_PIN_BS_HI 10
`define DHB_PIN_BS_LO 8
`define DHB_PIN_D_HI 7
`define DHB_PIN_D_LO 0
`define DHB_PIN_SCLK 0
`define DHB_PIN_SERIAL_IN_LINE 1

// ==========================================
// Serial frame lengths and reset values
`define DHB_SPI4_BITS 4'h8
`define DHB_SPI3_BITS 4'h9
`define DHB_CNT_ZERO 4'h0
`define DHB_CNT_ONE 4'h1
`define DHB_BYTE_ZERO 8'h00
`define DHB_WORD_W 9
`define DHB_SHIFT_W 9

`endif

// ---- hw/dhb_pkg.sv ----
// Types shared by the display host bus front end
`default_nettype none
`include "dhb_defs.svh"

package dhb_pkg;

   // ==========================================
   // Bus modes, coded as the strap pins read
   typedef enum logic [2:0] {
      DHB_TWO_WIRE = `DHB_BS_TWO_WIRE,
      DHB_P6800 = `DHB_BS_P6800,
      DHB_P8080 = `DHB_BS_P8080,
      DHB_SPI4 = `DHB_BS_SPI4,
      DHB_SPI3 = `DHB_BS_SPI3,
      DHB_NONE = `DHB_BS_NONE
   } dhb_mode_t;

endpackage

`default_nettype wire

// ---- hw/dhb_skid_buffer.sv ----
// Two-entry buffer with registered valid and ready on both sides
`default_nettype none

module dhb_skid_buffer #(
   parameter int WIDTH = 9
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   logic [WIDTH-1:0] spareData;
   logic spareValid;
   logic push;
   logic pop;

   // ==========================================
   // Handshake terms
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // ==========================================
   // Storage
   // Ready comes from a flop, so the filler never sees a combinational path
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         outValid <= 1'b0;
         spareValid <= 1'b0;
         inReady <= 1'b1;
         outData <= '0;
         spareData <= '0;
      end else if (pop) begin
         if (spareValid) begin
            outData <= spareData;
            spareValid <= 1'b0;
            inReady <= 1'b1;
         end else begin
            outValid <= push;
            if (push) begin
               outData <= inData;
            end
         end
      end else if (push) begin
         if (!outValid) begin
            outData <= inData;
            outValid <= 1'b1;
         end else begin
            spareData <= inData;
            spareValid <= 1'b1;
            inReady <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ---- test/dhb_host_frontend_asserts.sv ----
// Concurrent checks on the host bus front end ports
`default_nettype none

module dhb_host_frontend_asserts (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic hwResetInN,
   input wire logic chipSelN,
   input wire logic [2:0] busModeSel,
   input wire logic dataOe,
   input wire logic frameRdNext,
   input wire logic wrValid,
   input wire logic wrReady,
   input wire logic [7:0] wrData,
   input wire logic wrIsData,
   input wire logic targetAddrLsb,
   input wire dhb_pkg::dhb_mode_t busMode,
   input wire logic displayOn,
   input wire logic rowDriversOe,
   input wire logic columnDriversEn,
   input wire logic frontendInit
);
   timeunit 1ns;
   timeprecision 1ps;
   import dhb_pkg::*;
   wire strapOk = busModeSel inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ==========================================
   // Sequences
   sequence strapHeld;
      (!srst && !hwResetInN && $stable(busModeSel)) [*6];
   endsequence
   sequence pinLow;
      (!srst && !hwResetInN) [*5];
   endsequence
   sequence csIdle;
      chipSelN [*8];
   endsequence
   // ==========================================
   // Properties
   chk_init_held: assert property (pinLow |-> frontendInit)
      else $error("init dropped while reset pin low");
   chk_cs_ignore: assert property (csIdle ##0 !wrValid |=> !wrValid)
      else $error("word appeared without chip select");
   chk_addr_lsb: assert property (busMode != DHB_TWO_WIRE && $past(busMode) != DHB_TWO_WIRE |-> !targetAddrLsb)
      else $error("address bit set outside two-wire mode");
   chk_mode_decode: assert property (strapHeld |-> busMode == (strapOk ? dhb_mode_t'(busModeSel) : DHB_NONE))
      else $error("bus mode does not match strap");
   chk_frame_pulse: assert property (frameRdNext |-> busMode inside {DHB_P6800, DHB_P8080} ##1 !frameRdNext)
      else $error("bad frame read advance");
   chk_serial_nodrive: assert property (busMode inside {DHB_SPI4, DHB_SPI3, DHB_TWO_WIRE} |-> !dataOe)
      else $error("bus driven in a write-only mode");
   chk_rows_float: assert property (!displayOn |=> !rowDriversOe)
      else $error("rows driven while display off");
   chk_cols_ground: assert property (!displayOn |=> !columnDriversEn)
      else $error("columns enabled while display off");
   chk_word_holds: assert property (wrValid && !wrReady |=> wrValid && $stable({wrData, wrIsData}))
      else $error("pending word changed before taken");
endmodule

bind dhb_host_frontend dhb_host_frontend_asserts chk (.*);

`default_nettype wire

// ---- test/dhb_host_model.sv ----
// Host microcontroller model for the parallel and serial pins
`default_nettype none

module dhb_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] busIn,
   output logic chipSelN,
   output logic dataCmdSel,
   output logic strobeERdN,
   output logic rwWrN,
   output logic [7:0] hostData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chipSelN = 1'b1;
      dataCmdSel = 1'b0;
      strobeERdN = 1'b1;
      rwWrN = 1'b1;
      hostData = 8'h00;
   end
   task automatic ph(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic park(input logic s, input logic r, input logic dcv);
      strobeERdN = s;
      rwWrN = r;
      dataCmdSel = dcv;
   endtask
   // Parallel cycle; a released bus shows the inverse of the last value
   task automatic xfer(input bit m68, input bit rd, input bit cs, input logic dcv, input logic [7:0] b,
                       output logic [7:0] v);
      @(negedge sys_clk);
      chipSelN = !cs;
      dataCmdSel = dcv;
      hostData = rd ? ~hostData : b;
      if (m68) begin
         rwWrN = rd;
         ph(5);
         strobeERdN = 1'b1;
      end else if (rd) begin
         ph(5);
         strobeERdN = 1'b0;
      end else begin
         ph(5);
         rwWrN = 1'b0;
      end
      ph(5);
      v = busIn;
      strobeERdN = !m68;
      // 6800 direction must outlast the enable fall
      if (!m68) begin
         rwWrN = 1'b1;
      end
      ph(5);
      chipSelN = 1'b1;
      rwWrN = 1'b1;
      ph(5);
   endtask
   task automatic tie_sda(input logic b);
      hostData[2] = b;
      hostData[1] = b;
   endtask
   // Serial frame of n bits, MSB first; clock stands low between frames
   task automatic ser(input int n, input logic dcv, input logic [8:0] w);
      @(negedge sys_clk);
      chipSelN = 1'b0;
      dataCmdSel = dcv;
      hostData = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         hostData[1] = w[i];
         ph(4);
         hostData[0] = 1'b1;
         ph(4);
         hostData[0] = 1'b0;
      end
      ph(4);
      chipSelN = 1'b1;
      hostData[1] = ~hostData[1];
      ph(4);
   endtask
endmodule

`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the display host bus front end
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dhb_pkg::*;
   logic sys_clk, srst, hwResetInN, wrReady, displayOn;
   logic [2:0] busModeSel;
   logic [7:0] addr, v;
   wire logic [7:0] dataIn, dataOut, hostData, frameRdData;
   wire logic chipSelN, dataCmdSel, strobeERdN, rwWrN, dataOe, frameRdNext, wrValid, wrIsData, wrOverrun;
   wire logic targetAddrLsb, rowDriversOe, columnDriversEn, frontendInit;
   wire logic [7:0] wrData;
   dhb_mode_t busMode;
   int bad_count = 0;
   int samples_checked = 0;
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always_ff @(posedge sys_clk) addr <= srst ? 8'h00 : addr + {7'h00, frameRdNext};
   assign frameRdData = 8'h50 + addr;
   assign dataIn = dataOe ? dataOut : hostData;
   dhb_host_model host (.sys_clk(sys_clk), .busIn(dataIn), .chipSelN(chipSelN), .dataCmdSel(dataCmdSel),
      .strobeERdN(strobeERdN), .rwWrN(rwWrN), .hostData(hostData));
   dhb_host_frontend dut (.sys_clk(sys_clk), .srst(srst), .hwResetInN(hwResetInN), .chipSelN(chipSelN),
      .dataCmdSel(dataCmdSel), .strobeERdN(strobeERdN), .rwWrN(rwWrN), .busModeSel(busModeSel),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .statusIn(8'h6B), .frameRdData(frameRdData),
      .frameRdNext(frameRdNext), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .wrIsData(wrIsData),
      .wrOverrun(wrOverrun), .targetAddrLsb(targetAddrLsb), .busMode(busMode), .displayOn(displayOn),
      .rowDriversOe(rowDriversOe), .columnDriversEn(columnDriversEn), .frontendInit(frontendInit));
   task automatic results();
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic set_mode(input logic [2:0] code);
      @(negedge sys_clk);
      busModeSel = code;
      hwResetInN = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(frontendInit, 1'b1);
      check(busMode, (code inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}) ? code : DHB_NONE);
      hwResetInN = 1'b1;
      displayOn = code[0];
      repeat (8) @(negedge sys_clk);
      check(frontendInit, 1'b0);
      check({rowDriversOe, columnDriversEn}, {2{code[0]}});
   endtask
   // Take one word from the buffer
   task automatic pop(input logic [8:0] exp);
      int i;
      i = 0;
      while (wrValid !== 1'b1 && i < 60) begin
         @(negedge sys_clk);
         i++;
      end
      if (i == 60) begin
         bad_count++;
         results();
      end
      check({wrIsData, wrData}, exp);
      wrReady = 1'b1;
      @(negedge sys_clk);
      wrReady = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic s_8080();
      host.park(1'b1, 1'b1, 1'b0);
      set_mode(3'h6);
      host.xfer(0, 0, 0, 1, 8'hFF, v);
      host.xfer(0, 0, 1, 0, 8'hA5, v);
      host.xfer(0, 0, 1, 1, 8'h3C, v);
      // Third word finds the buffer full
      host.xfer(0, 0, 1, 1, 8'h77, v);
      check(wrOverrun, 1'b1);
      pop({1'b0, 8'hA5});
      pop({1'b1, 8'h3C});
      repeat (10) @(negedge sys_clk);
      check(wrValid, 1'b0);
      host.xfer(0, 1, 1, 0, 8'h00, v);
      check(v, 8'h6B);
      host.xfer(0, 1, 1, 1, 8'h00, v);
      host.xfer(0, 1, 1, 1, 8'h00, v);
      check(v, 8'h50);
      host.xfer(0, 1, 1, 1, 8'h00, v);
      check(v, 8'h51);
   endtask
   task automatic s_6800();
      host.park(1'b0, 1'b1, 1'b0);
      set_mode(3'h4);
      host.xfer(1, 0, 1, 1, 8'h81, v);
      pop({1'b1, 8'h81});
      host.xfer(1, 1, 1, 0, 8'h00, v);
      check(v, 8'h6B);
   endtask
   task automatic s_serial();
      host.park(1'b0, 1'b0, 1'b0);
      set_mode(3'h0);
      host.ser(8, 1, {1'b0, 8'hC3});
      pop({1'b1, 8'hC3});
      check(dataOe, 1'b0);
      host.ser(3, 1, 9'h005);
      host.ser(8, 0, 9'h05A);
      pop({1'b0, 8'h5A});
      set_mode(3'h1);
      host.ser(9, 0, {1'b1, 8'h96});
      pop({1'b1, 8'h96});
      host.ser(9, 0, {1'b0, 8'h0F});
      pop({1'b0, 8'h0F});
   endtask
   task automatic s_two_wire();
      set_mode(3'h2);
      host.park(1'b0, 1'b0, 1'b1);
      host.tie_sda(1'b1);
      repeat (8) @(negedge sys_clk);
      check(targetAddrLsb, 1'b1);
      check(dataOe, 1'b0);
      host.park(1'b0, 1'b0, 1'b0);
      repeat (8) @(negedge sys_clk);
      check(targetAddrLsb, 1'b0);
   endtask
   initial begin
      srst = 1'b1;
      hwResetInN = 1'b1;
      busModeSel = 3'h7;
      wrReady = 1'b0;
      displayOn = 1'b0;
      repeat (8) @(negedge sys_clk);
      srst = 1'b0;
      for (int c = 0; c < 8; c++)
         set_mode(3'(c));
      s_8080();
      s_6800();
      s_serial();
      s_two_wire();
      results();
   end
endmodule

`default_nettype wire
